// file: core/cevt_pkg.sv
// Purpose: shared constants for the charger event and interrupt logic
// Assumes: byte-wide register port with 8-bit addresses
// Notes: offsets are the register addresses seen on the register port
package cevt_pkg;
  // register offsets
  localparam logic [7:0] CEVT_OFF_STATUS = 8'h78;
  localparam logic [7:0] CEVT_OFF_ENABLE = 8'h79;
  localparam logic [7:0] CEVT_OFF_STATE = 8'h7A;
  // status byte field positions
  localparam int CEVT_ST_TIMR_GRP = 7;
  localparam int CEVT_ST_TEMP_GRP = 6;
  localparam int CEVT_ST_INP_GRP = 5;
  localparam int CEVT_ST_CHG_GRP = 4;
  localparam int CEVT_ST_TIMR_DAT = 3;
  localparam int CEVT_ST_TEMP_DAT = 2;
  localparam int CEVT_ST_INP_DAT = 1;
  localparam int CEVT_ST_EOC_DAT = 0;
  // enable byte field positions
  localparam int CEVT_EN_TOTAL = 7;
  localparam int CEVT_EN_TEMP_IN = 6;
  localparam int CEVT_EN_INP_CON = 5;
  localparam int CEVT_EN_EOC_IN = 4;
  localparam int CEVT_EN_PRE = 3;
  localparam int CEVT_EN_TEMP_OUT = 2;
  localparam int CEVT_EN_INP_DIS = 1;
  localparam int CEVT_EN_EOC_OUT = 0;
  // state byte field positions
  localparam int CEVT_SR_STATE_LSB = 4;
  localparam int CEVT_SR_SUPPLY = 1;
  // encoding of the end-of-charge state on the charging state input
  localparam logic [1:0] CEVT_STATE_EOC = 2'h3;
  // values after reset
  localparam logic [7:0] CEVT_ENABLE_RST = 8'h00;
  localparam logic [3:0] CEVT_ARM_RST = 4'h0;
  localparam logic [3:0] CEVT_PEND_RST = 4'h0;
  localparam logic [7:0] CEVT_RDATA_RST = 8'h00;
  localparam logic [5:0] CEVT_LVL_RST = 6'h00;
  // group indexes into the arm and pending vectors
  localparam int CEVT_G_CHG = 0;
  localparam int CEVT_G_INP = 1;
  localparam int CEVT_G_TEMP = 2;
  localparam int CEVT_G_TIMR = 3;
endpackage

// file: core/cevt_charger_irq.sv
// Purpose: charger status readout and event interrupt logic
// Assumes: all inputs except rst_n synchronous to mclk; registers reached on a byte port
// Notes: pending group flags clear on a read of the status byte
`timescale 1ns/1ns
module cevt_charger_irq
  import cevt_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // charger status inputs
  input wire logic temp_in_window,
  input wire logic charger_supply_pin,
  input wire logic [1:0] charging_state,
  input wire logic precharge_timeout,
  input wire logic total_timeout,
  input wire logic supply_type_detect_pin,
  // open-drain interrupt pin
  output logic interrupt_out_n,
  output logic interrupt_out_n_oe
);
  import cevt_pkg::*;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] irq_enable;
  logic [3:0] group_arm;
  logic [3:0] group_pend;
  logic [5:0] prev_lvl;
  logic [7:0] next_irq_enable;
  logic [3:0] next_group_arm;
  logic [3:0] next_group_pend;
  logic [5:0] next_prev_lvl;
  logic [7:0] next_reg_rdata;
  logic end_of_charge_flag;
  logic [5:0] cur_lvl;
  logic [7:0] ev;
  logic [3:0] grp_hit;
  logic [7:0] status_byte;
  logic [7:0] state_byte;
  logic rd_status;

  // level vector: total, precharge, temp, input, eoc, spare
  assign end_of_charge_flag = (charging_state == CEVT_STATE_EOC);
  assign cur_lvl = {total_timeout, precharge_timeout, temp_in_window, charger_supply_pin,
                    end_of_charge_flag, 1'b0};

  // edge detect so a steady level never re-fires
  always_comb
  begin
    ev = 8'h00;
    ev[CEVT_EN_TOTAL] = cur_lvl[5] & ~prev_lvl[5];
    ev[CEVT_EN_PRE] = cur_lvl[4] & ~prev_lvl[4];
    ev[CEVT_EN_TEMP_IN] = cur_lvl[3] & ~prev_lvl[3];
    ev[CEVT_EN_TEMP_OUT] = ~cur_lvl[3] & prev_lvl[3];
    ev[CEVT_EN_INP_CON] = cur_lvl[2] & ~prev_lvl[2];
    ev[CEVT_EN_INP_DIS] = ~cur_lvl[2] & prev_lvl[2];
    ev[CEVT_EN_EOC_IN] = cur_lvl[1] & ~prev_lvl[1];
    ev[CEVT_EN_EOC_OUT] = ~cur_lvl[1] & prev_lvl[1];
  end

  // an event counts only when its enable and its group arm are both set
  always_comb
  begin
    grp_hit[CEVT_G_TIMR] = group_arm[CEVT_G_TIMR] & ((ev[CEVT_EN_TOTAL] & irq_enable[CEVT_EN_TOTAL])
                         | (ev[CEVT_EN_PRE] & irq_enable[CEVT_EN_PRE]));
    grp_hit[CEVT_G_TEMP] = group_arm[CEVT_G_TEMP] & ((ev[CEVT_EN_TEMP_IN] & irq_enable[CEVT_EN_TEMP_IN])
                         | (ev[CEVT_EN_TEMP_OUT] & irq_enable[CEVT_EN_TEMP_OUT]));
    grp_hit[CEVT_G_INP] = group_arm[CEVT_G_INP] & ((ev[CEVT_EN_INP_CON] & irq_enable[CEVT_EN_INP_CON])
                        | (ev[CEVT_EN_INP_DIS] & irq_enable[CEVT_EN_INP_DIS]));
    grp_hit[CEVT_G_CHG] = group_arm[CEVT_G_CHG] & ((ev[CEVT_EN_EOC_IN] & irq_enable[CEVT_EN_EOC_IN])
                        | (ev[CEVT_EN_EOC_OUT] & irq_enable[CEVT_EN_EOC_OUT]));
  end

  // read images of the two status bytes
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[CEVT_ST_TIMR_GRP] = group_pend[CEVT_G_TIMR];
    status_byte[CEVT_ST_TEMP_GRP] = group_pend[CEVT_G_TEMP];
    status_byte[CEVT_ST_INP_GRP] = group_pend[CEVT_G_INP];
    status_byte[CEVT_ST_CHG_GRP] = group_pend[CEVT_G_CHG];
    status_byte[CEVT_ST_TIMR_DAT] = precharge_timeout | total_timeout;
    status_byte[CEVT_ST_TEMP_DAT] = temp_in_window;
    status_byte[CEVT_ST_INP_DAT] = charger_supply_pin;
    status_byte[CEVT_ST_EOC_DAT] = end_of_charge_flag;
    state_byte = 8'h00;
    state_byte[CEVT_SR_STATE_LSB +: 2] = charging_state;
    state_byte[CEVT_SR_SUPPLY] = supply_type_detect_pin;
  end

  ////////////////////////////////////////////////////////////////////////
  // next values; a new event in the same cycle as the clearing read wins
  assign rd_status = reg_rd & addr_hit(reg_addr, CEVT_OFF_STATUS);
  always_comb
  begin
    next_irq_enable = irq_enable;
    next_group_arm = group_arm;
    next_prev_lvl = cur_lvl;
    next_group_pend = grp_hit | (group_pend & {4{~rd_status}});
    next_reg_rdata = reg_rdata;
    if (reg_wr && addr_hit(reg_addr, CEVT_OFF_ENABLE))
      next_irq_enable = reg_wdata;
    if (reg_wr && addr_hit(reg_addr, CEVT_OFF_STATUS))
      next_group_arm = reg_wdata[CEVT_ST_CHG_GRP +: 4];
    if (reg_rd)
    begin
      if (addr_hit(reg_addr, CEVT_OFF_STATUS))
        next_reg_rdata = status_byte;
      else if (addr_hit(reg_addr, CEVT_OFF_ENABLE))
        next_reg_rdata = irq_enable;
      else if (addr_hit(reg_addr, CEVT_OFF_STATE))
        next_reg_rdata = state_byte;
      else
        next_reg_rdata = 8'h00; // unmapped reads return zero
    end
  end

  // register the state
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      irq_enable <= CEVT_ENABLE_RST;
      group_arm <= CEVT_ARM_RST;
      group_pend <= CEVT_PEND_RST;
      prev_lvl <= CEVT_LVL_RST;
      reg_rdata <= CEVT_RDATA_RST;
    end
    else
    begin
      irq_enable <= next_irq_enable;
      group_arm <= next_group_arm;
      group_pend <= next_group_pend;
      prev_lvl <= next_prev_lvl;
      reg_rdata <= next_reg_rdata;
    end
  end

  // open drain: pull low only while something is pending
  assign interrupt_out_n = 1'b0;
  assign interrupt_out_n_oe = |group_pend;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_total_irq;
    @(posedge mclk) disable iff (!rst_sync_n)
    (total_timeout && !$past(total_timeout) && irq_enable[CEVT_EN_TOTAL] && group_arm[CEVT_G_TIMR])
      |=> group_pend[CEVT_G_TIMR] ##0 interrupt_out_n_oe;
  endproperty
  a_total_irq: assert property (p_total_irq) else $error("total timeout did not pend");

  property p_pre_blocked;
    @(posedge mclk) disable iff (!rst_sync_n)
    (!group_arm[CEVT_G_TIMR] && !group_pend[CEVT_G_TIMR]) |=> !group_pend[CEVT_G_TIMR];
  endproperty
  a_pre_blocked: assert property (p_pre_blocked) else $error("timer group pended unarmed");

  // the precharge expiry must pend on its own, not only through the total timer
  property p_pre_irq;
    @(posedge mclk) disable iff (!rst_sync_n)
    ($rose(precharge_timeout) && irq_enable[CEVT_EN_PRE] && group_arm[CEVT_G_TIMR])
      |=> group_pend[CEVT_G_TIMR];
  endproperty
  a_pre_irq: assert property (p_pre_irq) else $error("precharge timeout did not pend");

  property p_temp_in;
    @(posedge mclk) disable iff (!rst_sync_n)
    ($rose(temp_in_window) && irq_enable[CEVT_EN_TEMP_IN] && group_arm[CEVT_G_TEMP])
      |=> status_byte[CEVT_ST_TEMP_GRP];
  endproperty
  a_temp_in: assert property (p_temp_in) else $error("temperature entry missed");

  property p_temp_out;
    @(posedge mclk) disable iff (!rst_sync_n)
    ($fell(temp_in_window) && irq_enable[CEVT_EN_TEMP_OUT] && group_arm[CEVT_G_TEMP])
      |=> group_pend[CEVT_G_TEMP];
  endproperty
  a_temp_out: assert property (p_temp_out) else $error("temperature exit missed");

  property p_inp;
    @(posedge mclk) disable iff (!rst_sync_n)
    ($changed(charger_supply_pin) && group_arm[CEVT_G_INP]
      && irq_enable[charger_supply_pin ? CEVT_EN_INP_CON : CEVT_EN_INP_DIS]) |=> group_pend[CEVT_G_INP];
  endproperty
  a_inp: assert property (p_inp) else $error("input event missed");

  property p_eoc;
    @(posedge mclk) disable iff (!rst_sync_n)
    ($changed(end_of_charge_flag) && group_arm[CEVT_G_CHG]
      && irq_enable[end_of_charge_flag ? CEVT_EN_EOC_IN : CEVT_EN_EOC_OUT]) |=> group_pend[CEVT_G_CHG];
  endproperty
  a_eoc: assert property (p_eoc) else $error("end-of-charge event missed");

  property p_steady;
    @(posedge mclk) disable iff (!rst_sync_n)
    (rd_status && $stable(cur_lvl)) |=> (group_pend == 4'h0);
  endproperty
  a_steady: assert property (p_steady) else $error("steady level retriggered");

  property p_irq_pin;
    @(posedge mclk) disable iff (!rst_sync_n)
    (group_pend != 4'h0) |-> (interrupt_out_n_oe && !interrupt_out_n);
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not driven");

  property p_read_state;
    @(posedge mclk) disable iff (!rst_sync_n)
    (reg_rd && reg_addr == CEVT_OFF_STATE) |=>
      (reg_rdata[5:4] == $past(charging_state) && reg_rdata[1] == $past(supply_type_detect_pin)
       && reg_rdata[7:6] == 2'h0);
  endproperty
  a_read_state: assert property (p_read_state) else $error("state byte wrong");

  property p_read_status;
    @(posedge mclk) disable iff (!rst_sync_n)
    (reg_rd && reg_addr == CEVT_OFF_STATUS) |=>
      (reg_rdata[2:0] == {$past(temp_in_window), $past(charger_supply_pin), $past(end_of_charge_flag)});
  endproperty
  a_read_status: assert property (p_read_status) else $error("status byte wrong");
endmodule

// file: tb/cevt_host_model.sv
// Purpose: host side model, register port master and pulled-up interrupt line
// Assumes: one register request at a time, launched just after a rising edge
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ns
module cevt_host_model
(
  // clock
  input wire logic mclk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // open-drain interrupt pin
  input wire logic interrupt_out_n,
  input wire logic interrupt_out_n_oe,
  output logic irq_line
);
  ////////////////////////////////////////////////////////////////////////////
  // board pull-up wins whenever the device lets go of the pin
  assign irq_line = interrupt_out_n_oe ? interrupt_out_n : 1'h1;
  // idle bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end
  // one write, taken at the edge after launch
  task automatic host_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // one read, data registered at the taking edge, picked up at mid-cycle
  task automatic host_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    @(negedge mclk);
    d = reg_rdata;
  endtask
endmodule

// file: tb/cevt_charger_irq_bench.sv
// Purpose: self-checking bench for the charger event interrupt logic
// Assumes: host model drives the register port
// Notes: each event is tried armed, with wrong enable and with wrong group
`timescale 1ns/1ns
module cevt_charger_irq_bench;
  import cevt_pkg::*;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, exp;
  logic reg_wr, reg_rd, interrupt_out_n, interrupt_out_n_oe, irq_line;
  logic temp_in_window = 1'h0;
  logic charger_supply_pin = 1'h0;
  logic [1:0] charging_state = 2'h0;
  logic precharge_timeout = 1'h0;
  logic total_timeout = 1'h0;
  logic supply_type_detect_pin = 1'h0;
  int err_count = 0;
  int check_count = 0;
  int g;
  // input sets {total, pre, temp, supply, eoc} around each enable bit k
  logic [4:0] ev_before [8] = '{5'h01, 5'h02, 5'h04, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
  logic [4:0] ev_after [8] = '{5'h00, 5'h00, 5'h00, 5'h08, 5'h01, 5'h02, 5'h04, 5'h10};
  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  always #10 mclk = ~mclk;
  cevt_charger_irq uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .temp_in_window(temp_in_window),
    .charger_supply_pin(charger_supply_pin), .charging_state(charging_state),
    .precharge_timeout(precharge_timeout), .total_timeout(total_timeout),
    .supply_type_detect_pin(supply_type_detect_pin), .interrupt_out_n(interrupt_out_n),
    .interrupt_out_n_oe(interrupt_out_n_oe));
  cevt_host_model hm (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .interrupt_out_n(interrupt_out_n),
    .interrupt_out_n_oe(interrupt_out_n_oe), .irq_line(irq_line));
  ////////////////////////////////////////////////////////////////////////////
  // comparisons: register bytes and the interrupt pin
  task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] got);
    check_count++;
    if (got !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic check_bit(input string what, input logic e, input logic got);
    check_count++;
    if (got !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, got);
    end
  endtask
  task automatic read_check(input string what, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    hm.host_read(a, d);
    check_byte(what, e, d);
  endtask
  // charger inputs change just after an edge
  task automatic set_inputs(input logic [4:0] v);
    @(posedge mclk);
    total_timeout <= v[4];
    precharge_timeout <= v[3];
    temp_in_window <= v[2];
    charger_supply_pin <= v[1];
    charging_state <= v[0] ? CEVT_STATE_EOC : 2'h1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: the run needs well under a thousand cycles
  initial
  begin
    #400000;
    err_count++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    check_bit("irq idle", 1'h1, irq_line);
    read_check("enable reset", CEVT_OFF_ENABLE, 8'h00);
    read_check("status reset", CEVT_OFF_STATUS, 8'h00);
    @(posedge mclk);
    charging_state <= 2'h2;
    supply_type_detect_pin <= 1'h1;
    repeat (3) @(posedge mclk);
    read_check("state", CEVT_OFF_STATE, 8'h22);
    hm.host_write(CEVT_OFF_STATE, 8'hFF);
    read_check("state write", CEVT_OFF_STATE, 8'h22);
    hm.host_write(CEVT_OFF_ENABLE, 8'hA5);
    hm.host_write(8'h7B, 8'h5A);
    read_check("enable", CEVT_OFF_ENABLE, 8'hA5);
    read_check("unmapped", 8'h7B, 8'h00);
    // every event: armed, enable of other events only, other groups only
    for (int k = 0; k < 8; k++)
      for (int p = 0; p < 3; p++)
      begin
        g = 4 + (k % 4);
        hm.host_write(CEVT_OFF_ENABLE, 8'h00);
        set_inputs(ev_before[k]);
        repeat (3) @(posedge mclk);
        hm.host_read(CEVT_OFF_STATUS, rd);
        check_byte("status idle", {4'h0, ev_before[k][4] | ev_before[k][3], ev_before[k][2:0]}, rd);
        hm.host_write(CEVT_OFF_ENABLE, (p == 1) ? ~(8'h01 << k) : (8'h01 << k));
        hm.host_write(CEVT_OFF_STATUS, (p == 2) ? (8'hF0 & ~(8'h01 << g)) : 8'hF0);
        set_inputs(ev_after[k]);
        repeat (3) @(posedge mclk);
        exp = (p == 0) ? (8'h01 << g) : 8'h00;
        check_bit("irq event", (exp == 8'h00), irq_line);
        exp = exp | {4'h0, ev_after[k][4] | ev_after[k][3], ev_after[k][2:0]};
        read_check("status event", CEVT_OFF_STATUS, exp);
        repeat (3) @(posedge mclk);
        check_bit("irq serviced", 1'h1, irq_line);
      end
    end_of_test();
  end
endmodule
